// ### rtl/irq_bank_map.svh
// register offsets, field positions and the priority reset value of the flag, enable and priority bank
`ifndef IRQ_BANK_MAP_SVH
`define IRQ_BANK_MAP_SVH
`define ADDR_FLAG1      4'h0
`define ADDR_FLAG3      4'h1
`define ADDR_FLAG4      4'h2
`define ADDR_EN0        4'h3
`define ADDR_EN1        4'h4
`define ADDR_EN3        4'h5
`define ADDR_EN4        4'h6
`define ADDR_PRIO0      4'h7
`define ADDR_CPU_LEVEL  4'h8
`define ADDR_IRQ_STAT   4'h9
`define ADDR_IRQ_MASK   4'ha
`define MASK_FLAG1      16'h20db
`define MASK_FLAG3      16'h8600
`define MASK_FLAG4      16'h0602
`define MASK_EN0        16'h3fef
`define MASK_PRIO0      16'h7777
`define MASK_LEVEL      16'h000f
`define MASK_STAT       16'h0007
`define RESET_PRIO0     16'h4444
`define PRIO_TIMER_A    14:12
`define PRIO_COMPARE1   10:8
`define PRIO_CAPTURE1   6:4
`define PRIO_EXT_IRQ0   2:0
`define BIT_EXT_IRQ0    0
`define BIT_CAPTURE1    1
`define BIT_COMPARE1    2
`define BIT_TIMER_A     3
`define LEVEL_TOP_BIT   3
`define PRIO_OFF        3'h0
`define PRIO_STRIDE     4
`define PRIO_WIDTH      3
`define BIT_EXT_IRQ2    13
`define BIT_CAPTURE8    7
`define BIT_CAPTURE7    6
`define BIT_EXT_IRQ1    4
`define BIT_CHG_NOTIFY  3
`define BIT_TW_MASTER   1
`define BIT_TW_SLAVE    0
`define BIT_PWM_A_FAULT 15
`define BIT_ENCODER     10
`define BIT_PWM_A_ERR   9
`define BIT_PWM_B_FAULT 10
`define BIT_PWM_B_ERR   9
`define BIT_SERIAL_ERR  1
`endif

// ### rtl/irq_bank_pkg.sv
// types of the flag, enable and priority bank
package irq_bank_pkg;
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_type;
	typedef struct packed {
		logic [15:0] flag1;
		logic [15:0] flag3;
		logic [15:0] flag4;
		logic [15:0] en0;
		logic [15:0] en1;
		logic [15:0] en3;
		logic [15:0] en4;
		logic [15:0] prio0;
		logic [3:0]  cpu_level;
		logic [2:0]  stat;
		logic [2:0]  mask;
		logic [15:0] rdata;
		logic [15:0] pend1;
		logic [15:0] pend3;
		logic [15:0] pend4;
		logic [3:0]  pend0;
		logic        irq;
	} bank_state_type;
endpackage

// ### rtl/irq_flag_enable_bank.sv
// flag, enable and priority register bank of the interrupt controller
`include "irq_bank_map.svh"
module irq_flag_enable_bank
	import irq_bank_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	input  wire logic [15:0] req1,
	input  wire logic [15:0] req3,
	input  wire logic [15:0] req4,
	input  wire logic [3:0]  req0,
	input  wire logic [3:0]  req0_flag_held,
	output logic      [15:0] pend1,
	output logic      [15:0] pend3,
	output logic      [15:0] pend4,
	output logic      [3:0]  pend0,
	output logic      [11:0] prio0_out,
	output logic      [3:0]  cpu_level,
	output logic             irq
);
	bank_state_type s_q;
	bank_state_type s_d;
	bus_req_type    b;
	logic [3:0]     prio_on;
	logic [3:0]     prio_allowed;
	logic [2:0]     ev;
	logic [15:0]    wm1;
	logic [15:0]    wm3;
	logic [15:0]    wm4;

	// bundle the bus port
	assign b = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// per-field priority checks for the four sources of the first priority word
	// rank against cpu level
	// source k owns the priority field that starts at bit k times the stride
	for (genvar k = 0; k < 4; k++) begin : g_src
		assign prio_on[k]      = s_q.prio0[`PRIO_STRIDE*k +: `PRIO_WIDTH] != `PRIO_OFF;
		assign prio_allowed[k] = {1'b0, s_q.prio0[`PRIO_STRIDE*k +: `PRIO_WIDTH]}
			> s_q.cpu_level;
	end

	// write masks of the flag words
	assign wm1 = `MASK_FLAG1;
	assign wm3 = `MASK_FLAG3;
	assign wm4 = `MASK_FLAG4;

	// next state: bus writes, request capture, pending and interrupt
	always_comb begin
		s_d = s_q;
		ev  = 3'h0;
		if (b.wr) begin
			unique case (b.addr)
				`ADDR_FLAG1:     s_d.flag1 = b.wdata & wm1;
				`ADDR_FLAG3:     s_d.flag3 = b.wdata & wm3;
				`ADDR_FLAG4:     s_d.flag4 = b.wdata & wm4;
				`ADDR_EN0:       s_d.en0 = b.wdata & `MASK_EN0;
				`ADDR_EN1:       s_d.en1 = b.wdata & wm1;
				`ADDR_EN3:       s_d.en3 = b.wdata & wm3;
				`ADDR_EN4:       s_d.en4 = b.wdata & wm4;
				`ADDR_PRIO0:     s_d.prio0 = b.wdata & `MASK_PRIO0;
				`ADDR_CPU_LEVEL: s_d.cpu_level = b.wdata[3:0];
				`ADDR_IRQ_MASK:  s_d.mask = b.wdata[2:0];
				default:         s_d.rdata = s_d.rdata;
			endcase
		end
		// requests set flags, set wins over a clearing write
		s_d.flag1 = s_d.flag1 | (req1 & wm1);
		s_d.flag3 = s_d.flag3 | (req3 & wm3);
		s_d.flag4 = s_d.flag4 | (req4 & wm4);
		ev[0] = |(req1 & wm1 & ~s_q.flag1);
		ev[1] = |(req3 & wm3 & ~s_q.flag3);
		ev[2] = |(req4 & wm4 & ~s_q.flag4);
		// read data, one cycle after the strobe
		s_d.rdata = 16'h0000;
		if (b.rd) begin
			unique case (b.addr)
				`ADDR_FLAG1:     s_d.rdata = s_q.flag1;
				`ADDR_FLAG3:     s_d.rdata = s_q.flag3;
				`ADDR_FLAG4:     s_d.rdata = s_q.flag4;
				`ADDR_EN0:       s_d.rdata = s_q.en0;
				`ADDR_EN1:       s_d.rdata = s_q.en1;
				`ADDR_EN3:       s_d.rdata = s_q.en3;
				`ADDR_EN4:       s_d.rdata = s_q.en4;
				`ADDR_PRIO0:     s_d.rdata = s_q.prio0;
				`ADDR_CPU_LEVEL: s_d.rdata = {12'h000, s_q.cpu_level};
				`ADDR_IRQ_STAT:  s_d.rdata = {13'h0000, s_q.stat};
				`ADDR_IRQ_MASK:  s_d.rdata = {13'h0000, s_q.mask};
				default:         s_d.rdata = 16'h0000;
			endcase
		end
		// sticky events cleared by a status read, new events win
		if (b.rd && b.addr == `ADDR_IRQ_STAT)
			s_d.stat = 3'h0;
		s_d.stat = s_d.stat | ev;
		// pending when flag and enable are set
		s_d.pend1 = s_q.flag1 & s_q.en1;
		s_d.pend3 = s_q.flag3 & s_q.en3;
		s_d.pend4 = s_q.flag4 & s_q.en4;
		// top level bit blocks user sources
		s_d.pend0 = req0_flag_held & s_q.en0[3:0] & prio_on & prio_allowed
			& {4{~s_q.cpu_level[`LEVEL_TOP_BIT]}};
		s_d.irq = |(s_q.stat & s_q.mask);
	end

	// state register
	// priority reset value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q       <= '0;
			s_q.prio0 <= `RESET_PRIO0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	assign rdata     = s_q.rdata;
	assign pend1     = s_q.pend1;
	assign pend3     = s_q.pend3;
	assign pend4     = s_q.pend4;
	assign pend0     = s_q.pend0;
	assign prio0_out = {s_q.prio0[`PRIO_TIMER_A], s_q.prio0[`PRIO_COMPARE1],
		s_q.prio0[`PRIO_CAPTURE1], s_q.prio0[`PRIO_EXT_IRQ0]};
	assign cpu_level = s_q.cpu_level;
	assign irq       = s_q.irq;

	// a request shows in the flag at the next edge
	a_flag_set: assert property (@(posedge clk) disable iff (rst)
		req1[`BIT_EXT_IRQ2] |=> s_q.flag1[`BIT_EXT_IRQ2])
		else $error("flag not set by request");
	a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		((s_q.flag1 & ~`MASK_FLAG1) == 16'h0000 && (s_q.prio0 & ~`MASK_PRIO0) == 16'h0000))
		else $error("reserved bit set");
	// unassigned flag bits of the other words
	a_flag_gaps: assert property (@(posedge clk) disable iff (rst)
		((s_q.flag3 & ~`MASK_FLAG3) == 16'h0000 && (s_q.flag4 & ~`MASK_FLAG4) == 16'h0000))
		else $error("reserved flag bit set");
	a_enable_gaps: assert property (@(posedge clk) disable iff (rst)
		((s_q.en0 & ~`MASK_EN0) == 16'h0000 && (s_q.en1 & ~`MASK_FLAG1) == 16'h0000
		&& (s_q.en3 & ~`MASK_FLAG3) == 16'h0000 && (s_q.en4 & ~`MASK_FLAG4) == 16'h0000))
		else $error("reserved enable bit set");
	a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
		!rd |=> rdata == 16'h0000) else $error("read data not idle");
	// flags hold without request or write
	a_flag_hold: assert property (@(posedge clk) disable iff (rst)
		(!(wr && addr == `ADDR_FLAG1) && req1 == 16'h0000) |=> $stable(s_q.flag1))
		else $error("flag changed by itself");
	a_flag_clear: assert property (@(posedge clk) disable iff (rst)
		(wr && addr == `ADDR_FLAG1 && req1 == 16'h0000)
		|=> s_q.flag1 == ($past(wdata) & `MASK_FLAG1))
		else $error("flag write lost");
	a_ext1_set: assert property (@(posedge clk) disable iff (rst)
		req1[`BIT_EXT_IRQ1] |=> s_q.flag1[`BIT_EXT_IRQ1])
		else $error("ext irq1 flag not set");
	a_capture_set: assert property (@(posedge clk) disable iff (rst)
		req1[`BIT_CAPTURE8] |=> s_q.flag1[`BIT_CAPTURE8])
		else $error("capture flag not set");
	a_notify_set: assert property (@(posedge clk) disable iff (rst)
		req1[`BIT_CHG_NOTIFY] |=> s_q.flag1[`BIT_CHG_NOTIFY])
		else $error("notify flag not set");
	a_encoder_set: assert property (@(posedge clk) disable iff (rst)
		req3[`BIT_ENCODER] |=> s_q.flag3[`BIT_ENCODER])
		else $error("encoder flag not set");
	a_serial_set: assert property (@(posedge clk) disable iff (rst)
		req4[`BIT_SERIAL_ERR] |=> s_q.flag4[`BIT_SERIAL_ERR])
		else $error("serial error flag not set");
	a_en0_write: assert property (@(posedge clk) disable iff (rst)
		(wr && addr == `ADDR_EN0) |=> s_q.en0 == ($past(wdata) & `MASK_EN0))
		else $error("enable write lost");
	a_en1_write: assert property (@(posedge clk) disable iff (rst)
		(wr && addr == `ADDR_EN1) |=> s_q.en1 == ($past(wdata) & `MASK_FLAG1))
		else $error("enable write lost");
	a_en3_write: assert property (@(posedge clk) disable iff (rst)
		(wr && addr == `ADDR_EN3) |=> s_q.en3 == ($past(wdata) & `MASK_FLAG3))
		else $error("enable write lost");
	a_en4_write: assert property (@(posedge clk) disable iff (rst)
		(wr && addr == `ADDR_EN4) |=> s_q.en4 == ($past(wdata) & `MASK_FLAG4))
		else $error("enable write lost");
	a_pend_later: assert property (@(posedge clk) disable iff (rst)
		##1 (pend3 == $past(s_q.flag3 & s_q.en3) && pend4 == $past(s_q.flag4 & s_q.en4)))
		else $error("later pending mismatch");
	a_level_write: assert property (@(posedge clk) disable iff (rst)
		(wr && addr == `ADDR_CPU_LEVEL) |=> s_q.cpu_level == $past(wdata[`LEVEL_TOP_BIT:0]))
		else $error("level write lost");
	a_prio_read: assert property (@(posedge clk) disable iff (rst)
		(rd && addr == `ADDR_PRIO0) |=> rdata == $past(s_q.prio0))
		else $error("priority read wrong");
	a_irq_level: assert property (@(posedge clk) disable iff (rst)
		##1 irq == $past(|(s_q.stat & s_q.mask))) else $error("irq level wrong");
	// status read clears when no event arrives
	a_stat_clear: assert property (@(posedge clk) disable iff (rst)
		(rd && addr == `ADDR_IRQ_STAT && req1 == 16'h0000 && req3 == 16'h0000
		&& req4 == 16'h0000) |=> s_q.stat == 3'h0)
		else $error("status not cleared");
	// timer a source fully qualified: held flag, enable, rank above level, not blocked
	sequence s_timer_a_ready;
		req0_flag_held[`BIT_TIMER_A] && s_q.en0[`BIT_TIMER_A]
		&& ({1'b0, s_q.prio0[`PRIO_TIMER_A]} > s_q.cpu_level)
		&& !s_q.cpu_level[`LEVEL_TOP_BIT];
	endsequence
	sequence s_timer_a_pends;
		##1 pend0[`BIT_TIMER_A];
	endsequence
	a_pend_source: assert property (@(posedge clk) disable iff (rst)
		s_timer_a_ready |-> s_timer_a_pends) else $error("source not pending");
	a_pend_cause: assert property (@(posedge clk) disable iff (rst)
		##1 pend1 == $past(s_q.flag1 & s_q.en1)) else $error("pending mismatch");
	a_prio_zero: assert property (@(posedge clk) disable iff (rst)
		(s_q.prio0[`PRIO_EXT_IRQ0] == `PRIO_OFF) |=> !pend0[`BIT_EXT_IRQ0])
		else $error("disabled source pending");
	a_level_block: assert property (@(posedge clk) disable iff (rst)
		s_q.cpu_level[`LEVEL_TOP_BIT] |=> pend0 == 4'h0)
		else $error("pending while blocked");
	a_enable_block: assert property (@(posedge clk) disable iff (rst)
		!s_q.en1[0] |=> !pend1[0]) else $error("pending while disabled");
	// priority at or below level blocks
	a_prio_rank: assert property (@(posedge clk) disable iff (rst)
		({1'b0, s_q.prio0[`PRIO_TIMER_A]} <= s_q.cpu_level) |=> !pend0[`BIT_TIMER_A])
		else $error("low priority pending");
	// priority reset value seen after reset
	a_prio_reset: assert property (@(posedge clk)
		$fell(rst) |-> s_q.prio0 == `RESET_PRIO0) else $error("priority reset wrong");
	a_prio_write: assert property (@(posedge clk) disable iff (rst)
		(wr && addr == `ADDR_PRIO0) |=> s_q.prio0 == ($past(wdata) & `MASK_PRIO0))
		else $error("priority write lost");
endmodule

// ### sim/irq_src_model.sv
// peripheral request sources that pulse the per-bit request lines
module irq_src_model
	import irq_bank_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic [47:0] word,
	output logic      [15:0] req1,
	output logic      [15:0] req3,
	output logic      [15:0] req4
);
	timeunit 1ns;
	timeprecision 100ps;
	always_ff @(posedge clk) begin
		{req1, req3, req4} <= go ? word : 48'h0;
	end
endmodule

// ### sim/tb_top.sv
// self-checking bench of the flag, enable and priority bank
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, wr = 0, rd = 0, go = 0, rd_seen = 0, irq;
	logic [3:0] addr = 0, held = 0, pend0, cpu_level;
	logic [15:0] wdata = 0, rdata, pend1, pend3, pend4, rq1, rq3, rq4, r;
	logic [11:0] prio0_out;
	logic [47:0] word = 0;
	logic [15:0] q[$];
	logic [15:0] msk [8] = '{16'h20db, 16'h8600, 16'h0602, 16'h3fef,
		16'h20db, 16'h8600, 16'h0602, 16'h7777};
	int error_cnt = 0, n_checks = 0;
	irq_flag_enable_bank DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .req1(rq1), .req3(rq3), .req4(rq4), .req0(4'h0),
		.req0_flag_held(held), .pend1(pend1), .pend3(pend3), .pend4(pend4),
		.pend0(pend0), .prio0_out(prio0_out), .cpu_level(cpu_level), .irq(irq));
	irq_src_model src (.clk(clk), .go(go), .word(word), .req1(rq1), .req3(rq3), .req4(rq4));
	// free-running system clock
	always #12.5 clk = ~clk;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one bus cycle, driven just after the edge
	task automatic bus(input logic w, input logic rr, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= w;
		rd <= rr;
		addr <= a;
		wdata <= d;
	endtask
	task automatic rdr(input logic [3:0] a, input logic [15:0] e);
		q.push_back(e);
		bus(1'b0, 1'b1, a, 16'h0);
	endtask
	task automatic settle();
		bus(1'b0, 1'b0, 4'h0, 16'h0);
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic fire(input logic [47:0] w);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		word <= w;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task automatic wait_irq(input logic e);
		for (int k = 0; k < 8 && irq !== e; k++) begin
			@(posedge clk);
			#1;
		end
		chk({15'h0, irq}, {15'h0, e});
		if (irq !== e) stop_test();
	endtask
	// note which cycles carry read data
	always @(posedge clk) rd_seen <= rd;
	// read data stand in the cycle after the strobe, checked once settled
	always @(negedge clk) begin
		if (rd_seen) chk(rdata, q.pop_front());
	end
	initial begin
		r = $urandom(4130);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rdr(4'(i), i == 7 ? 16'h4444 : 16'h0);
		bus(1'b1, 1'b0, 4'hf, 16'hffff);
		rdr(4'hf, 16'h0);
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			bus(1'b1, 1'b0, 4'(i), 16'hffff);
			rdr(4'(i), msk[i]);
			bus(1'b1, 1'b0, 4'(i), r);
			rdr(4'(i), r & msk[i]);
		end
		for (int i = 0; i < 7; i++) bus(1'b1, 1'b0, 4'(i), 16'h0);
		bus(1'b1, 1'b0, 4'ha, 16'h0007);
		bus(1'b1, 1'b0, 4'h4, 16'h0041);
		bus(1'b1, 1'b0, 4'h6, 16'h0200);
		fire(48'hffff_ffff_ffff);
		wait_irq(1'b1);
		for (int i = 0; i < 3; i++) rdr(4'(i), msk[i]);
		rdr(4'h9, 16'h0007);
		settle();
		chk(pend1, 16'h0041);
		chk(pend3, 16'h0);
		chk(pend4, 16'h0200);
		chk({12'h0, cpu_level}, 16'h0);
		chk({15'h0, irq}, 16'h0);
		bus(1'b1, 1'b0, 4'h0, 16'h0);
		bus(1'b1, 1'b0, 4'ha, 16'h0);
		fire(48'hffff_ffff_ffff);
		settle();
		chk({15'h0, irq}, 16'h0);
		held <= 4'hf;
		bus(1'b1, 1'b0, 4'h3, 16'h000f);
		bus(1'b1, 1'b0, 4'h7, 16'h7340);
		bus(1'b1, 1'b0, 4'h8, 16'h0003);
		settle();
		chk({12'h0, pend0}, 16'h000a);
		chk({12'h0, cpu_level}, 16'h0003);
		chk({4'h0, prio0_out}, {4'h0, 3'd7, 3'd3, 3'd4, 3'd0});
		bus(1'b1, 1'b0, 4'h8, 16'h0008);
		rdr(4'h8, 16'h0008);
		settle();
		chk({12'h0, pend0}, 16'h0);
		stop_test();
	end
endmodule
